// ==== core/sas_map.svh ====
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH
// ==============================================================
// Register offsets
`define SAS_OFS_CTRL0 2'h0
`define SAS_OFS_CTRL1 2'h1
`define SAS_OFS_RESULT 2'h2
`define SAS_OFS_IRQ 2'h3
// ==============================================================
// Field positions
`define SAS_C0_ENABLE 0
`define SAS_C0_GO 1
`define SAS_C0_CHS_LSB 2
`define SAS_C1_REF_LSB 0
`define SAS_C1_CS_LSB 4
`define SAS_IRQ_FLAG 0
`define SAS_IRQ_EN 1
// ==============================================================
// Reset values and codes
`define SAS_RST_BYTE 8'h00
`define SAS_CS_RC 2'h3
`define SAS_CHS_FIXED 4'hF
// ==============================================================
// Timing
`define SAS_CLK_NS 10
`define SAS_INSTR_NS 40
`define SAS_LAST_TAD 4'h9
`endif

// ==== core/sas_pkg.sv ====
package sas_pkg;
	typedef enum logic [1:0] {SAS_IDLE, SAS_DELAY, SAS_CONV} sas_state_t;
	typedef enum logic [1:0] {SAS_REF_VDD, SAS_REF_EXT, SAS_REF_FIXED}
		sas_ref_t;
endpackage : sas_pkg

// ==== core/sas_sequencer.sv ====
// What this block does
// - Eight-bit successive approximation result into result register
// - Channel field routes one input to sampler
// - Reference field picks positive reference; negative ground
// - Clock select picks divider or RC clock
// - Full conversion lasts ten bit periods
// - Completion clears go, sets flag, loads result
// - Flag set on every completion regardless enable
// - Enabled interrupt completion in sleep wakes device
// - Runs only when enabled; go starts conversion
// - Software abort writes partial, fills last bit
// - Reset clears registers and stops conversion
// - Sleep operation only with RC clock
// - RC clock delays start one instruction cycle
// - Sleep, interrupt off: power down after completion
// - Non-RC clock: sleep aborts, powers down
// - Compare trigger sets go, resets timer
// - Reference codes 0x supply, 10 external, 11 fixed
// - Channel codes 0-4, 8-13, 1111 fixed reference
//
// The plain strobed port and the address map were left to the implementer.
`include "sas_map.svh"

module sas_sequencer
	import sas_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic compIn,
	input wire logic rcClkIn,
	input wire logic sleepReq,
	input wire logic triggerEvent,
	output logic [7:0] dacCode,
	output logic [3:0] channelSelect,
	output logic muxValid,
	output sas_ref_t refSelect,
	output logic analogOn,
	output logic sampleConnect,
	output logic convIrqFlag,
	output logic wakeReq,
	output logic timerReset
);
	localparam int INSTR_CLKS =
		(`SAS_INSTR_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS;
	localparam logic [2:0] DLY_LAST = 3'(INSTR_CLKS - 1);

	// ==============================================================
	// Decoding helpers
	function automatic logic [5:0] divLastOf(input logic [2:0] cs);
		logic [2:0] shiftBy;
		shiftBy = 3'({cs[1:0], 1'b0}) + {2'h0, cs[2]} + 3'h1;
		divLastOf = 6'((7'h01 << shiftBy) - 7'h01);
	endfunction : divLastOf

	function automatic logic chanLegal(input logic [3:0] ch);
		chanLegal = (ch <= 4'h4) || (ch >= 4'h8 && ch <= 4'hD) ||
			(ch == `SAS_CHS_FIXED);
	endfunction : chanLegal

	function automatic sas_ref_t refOf(input logic [1:0] f);
		if (!f[1]) begin
			refOf = SAS_REF_VDD;
		end else if (!f[0]) begin
			refOf = SAS_REF_EXT;
		end else begin
			refOf = SAS_REF_FIXED;
		end
	endfunction : refOf

	function automatic logic [7:0] partialFill(input logic [7:0] dac,
		input logic [3:0] cnt, input logic last);
		logic [3:0] undone;
		partialFill = dac;
		undone = (cnt == 4'h0) ? 4'h8 : 4'h9 - cnt;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < undone) begin
				partialFill[i] = last;
			end
		end
	endfunction : partialFill

	// ==============================================================
	// Input synchronisers
	// Comparator sees the held sample and the registered trial, so it
	// settles within the cycle and is read directly; two flops here
	// would make the divide-by-two clock decide from the previous trial
	logic rcS1, rcS2, rcS3;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rcS1 <= 1'b0;
			rcS2 <= 1'b0;
			rcS3 <= 1'b0;
		end else begin
			rcS1 <= rcClkIn;
			rcS2 <= rcS1;
			rcS3 <= rcS2;
		end
	end

	// ==============================================================
	// State
	sas_state_t state, next_state;
	logic enable, next_enable;
	logic [3:0] chanSel, next_chanSel;
	logic [2:0] clkSel, next_clkSel;
	logic [1:0] refField, next_refField;
	logic [7:0] convResult, next_convResult;
	logic irqFlag, next_irqFlag;
	logic irqEnable, next_irqEnable;
	logic [7:0] next_dacCode;
	logic [3:0] tadCnt, next_tadCnt;
	logic [5:0] divCnt, next_divCnt;
	logic [2:0] dlyCnt, next_dlyCnt;
	logic lastBit, next_lastBit;
	logic sleepDown, next_sleepDown;
	logic next_wakeReq, next_timerReset;
	logic [7:0] next_regRdata;

	logic wrC0, wrC1, wrRes, wrIrq, busy, rcSel, sleepKill, tick;
	logic enableNow, startReq, stopQuiet, swAbort, doneEvt;
	logic [2:0] bitIdx;

	assign wrC0 = regWr && regAddr == `SAS_OFS_CTRL0;
	assign wrC1 = regWr && regAddr == `SAS_OFS_CTRL1;
	assign wrRes = regWr && regAddr == `SAS_OFS_RESULT;
	assign wrIrq = regWr && regAddr == `SAS_OFS_IRQ;
	assign busy = state != SAS_IDLE;
	assign rcSel = clkSel[1:0] == `SAS_CS_RC;
	assign sleepKill = sleepReq && !rcSel;
	assign tick = rcSel ? (rcS2 && !rcS3) : (divCnt == divLastOf(clkSel));
	assign enableNow = wrC0 ? regWdata[`SAS_C0_ENABLE] : enable;
	assign startReq = enableNow && !sleepKill &&
		((wrC0 && regWdata[`SAS_C0_GO]) || triggerEvent);
	assign stopQuiet = busy &&
		(sleepKill || (wrC0 && !regWdata[`SAS_C0_ENABLE]));
	assign swAbort = busy && !stopQuiet && wrC0 && !regWdata[`SAS_C0_GO];
	assign doneEvt = state == SAS_CONV && tick &&
		tadCnt == `SAS_LAST_TAD && !stopQuiet && !swAbort;
	assign bitIdx = 3'(4'h8 - tadCnt);

	// ==============================================================
	// Next values
	always_comb begin
		next_state = state;
		next_enable = enable;
		next_chanSel = chanSel;
		next_clkSel = clkSel;
		next_refField = refField;
		next_convResult = convResult;
		next_irqFlag = irqFlag;
		next_irqEnable = irqEnable;
		next_dacCode = dacCode;
		next_tadCnt = tadCnt;
		next_divCnt = tick ? 6'h00 : divCnt + 6'h01;
		next_dlyCnt = dlyCnt;
		next_lastBit = lastBit;
		next_sleepDown = sleepDown && sleepReq;
		next_wakeReq = 1'b0;
		next_timerReset = triggerEvent;
		if (wrC0) begin
			next_enable = regWdata[`SAS_C0_ENABLE];
			next_chanSel = regWdata[`SAS_C0_CHS_LSB +: 4];
		end
		if (wrC1) begin
			next_clkSel = regWdata[`SAS_C1_CS_LSB +: 3];
			next_refField = regWdata[`SAS_C1_REF_LSB +: 2];
		end
		if (wrRes) begin
			next_convResult = regWdata;
		end
		if (wrIrq) begin
			next_irqFlag = regWdata[`SAS_IRQ_FLAG];
			next_irqEnable = regWdata[`SAS_IRQ_EN];
		end
		unique case (state)
			SAS_IDLE: begin
				if (startReq) begin
					next_dacCode = `SAS_RST_BYTE;
					next_tadCnt = 4'h0;
					next_divCnt = 6'h00;
					next_dlyCnt = 3'h0;
					next_lastBit = 1'b0;
					next_state = rcSel ? SAS_DELAY : SAS_CONV;
				end
			end
			SAS_DELAY: begin
				next_dlyCnt = dlyCnt + 3'h1;
				next_divCnt = 6'h00;
				if (dlyCnt == DLY_LAST) begin
					next_state = SAS_CONV;
				end
			end
			SAS_CONV: begin
				if (tick && tadCnt != `SAS_LAST_TAD) begin
					next_tadCnt = tadCnt + 4'h1;
					if (tadCnt == 4'h0) begin
						next_dacCode = 8'h80;
					end else begin
						next_dacCode[bitIdx] = compIn;
						next_lastBit = compIn;
						if (bitIdx != 3'h0) begin
							next_dacCode[bitIdx - 3'h1] = 1'b1;
						end
					end
				end
			end
		endcase
		if (stopQuiet) begin
			next_state = SAS_IDLE;
		end else if (swAbort) begin
			next_state = SAS_IDLE;
			next_convResult = partialFill(dacCode, tadCnt, lastBit);
		end else if (doneEvt) begin
			next_state = SAS_IDLE;
			next_convResult = dacCode;
			next_irqFlag = 1'b1;
			next_sleepDown = sleepReq && !irqEnable;
			next_wakeReq = sleepReq && irqEnable;
		end
		next_regRdata = `SAS_RST_BYTE;
		if (regRd) begin
			unique case (regAddr)
				`SAS_OFS_CTRL0:
					next_regRdata = {2'h0, chanSel, busy, enable};
				`SAS_OFS_CTRL1:
					next_regRdata = {1'b0, clkSel, 2'h0, refField};
				`SAS_OFS_RESULT:
					next_regRdata = convResult;
				`SAS_OFS_IRQ:
					next_regRdata = {6'h00, irqEnable, irqFlag};
			endcase
		end
	end

	// ==============================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= SAS_IDLE;
			enable <= 1'b0;
			chanSel <= 4'h0;
			clkSel <= 3'h0;
			refField <= 2'h0;
			convResult <= `SAS_RST_BYTE;
			irqFlag <= 1'b0;
			irqEnable <= 1'b0;
			dacCode <= `SAS_RST_BYTE;
			tadCnt <= 4'h0;
			divCnt <= 6'h00;
			dlyCnt <= 3'h0;
			lastBit <= 1'b0;
			sleepDown <= 1'b0;
			wakeReq <= 1'b0;
			timerReset <= 1'b0;
			regRdata <= `SAS_RST_BYTE;
		end else begin
			state <= next_state;
			enable <= next_enable;
			chanSel <= next_chanSel;
			clkSel <= next_clkSel;
			refField <= next_refField;
			convResult <= next_convResult;
			irqFlag <= next_irqFlag;
			irqEnable <= next_irqEnable;
			dacCode <= next_dacCode;
			tadCnt <= next_tadCnt;
			divCnt <= next_divCnt;
			dlyCnt <= next_dlyCnt;
			lastBit <= next_lastBit;
			sleepDown <= next_sleepDown;
			wakeReq <= next_wakeReq;
			timerReset <= next_timerReset;
			regRdata <= next_regRdata;
		end
	end

	// ==============================================================
	// Analog side controls
	// channel route
	assign channelSelect = chanSel;
	assign muxValid = chanLegal(chanSel);
	assign refSelect = refOf(refField);
	// Enable bit stays set while the converter is powered down in sleep
	assign analogOn = enable && !sleepKill && !sleepDown;
	assign sampleConnect = analogOn && state != SAS_CONV;
	assign convIrqFlag = irqFlag;

	// ==============================================================
	// Checks
	logic [3:0] tickSeen, next_tickSeen;
	always_comb begin
		next_tickSeen = tickSeen;
		if (state != SAS_CONV) begin
			next_tickSeen = 4'h0;
		end else if (tick && tickSeen != 4'hF) begin
			next_tickSeen = tickSeen + 4'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tickSeen <= 4'h0;
		end else begin
			tickSeen <= next_tickSeen;
		end
	end

	default clocking cbSys @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence seqRcEnter;
		state == SAS_IDLE ##1 state == SAS_DELAY;
	endsequence
	sequence seqRcHold;
		(state == SAS_DELAY)[*4] ##1 state != SAS_DELAY;
	endsequence

	AST_DONE_UPDATE: assert property (
		doneEvt |=> convResult == $past(dacCode) && irqFlag && !busy)
		else $error("completion did not update result, flag and go");
	AST_FLAG_ALWAYS: assert property (
		doneEvt && !irqEnable |=> irqFlag)
		else $error("flag not set with interrupt disabled");
	AST_FLAG_STICKY: assert property (
		irqFlag && !wrIrq |=> irqFlag)
		else $error("flag cleared without software write");
	AST_TEN_PERIODS: assert property (
		doneEvt |-> tickSeen == 4'h9 && tick)
		else $error("conversion did not take ten bit periods");
	AST_RC_DELAY: assert property (
		seqRcEnter |-> seqRcHold)
		else $error("RC start delay is not one instruction cycle");
	AST_SLEEP_ABORT: assert property (
		busy && sleepReq && !rcSel |=> !busy && !analogOn &&
			convResult == $past(convResult) && enable == $past(enable))
		else $error("sleep did not abort a non RC conversion");
	AST_TRIGGER: assert property (
		triggerEvent && state == SAS_IDLE && enable && !wrC0 &&
			!sleepKill |=> busy && timerReset)
		else $error("trigger did not start conversion and reset timer");
	AST_PARTIAL: assert property (
		swAbort && tadCnt != 4'h0 |=> !busy &&
			convResult[0] == $past(lastBit))
		else $error("abort result not filled with last bit");
	AST_WAKE: assert property (
		doneEvt && irqEnable && sleepReq |=> wakeReq)
		else $error("no wake on completion in sleep");
	AST_GO_HOLD: assert property (
		state == SAS_CONV && !stopQuiet && !swAbort && !doneEvt
			|=> busy && (convResult == $past(convResult) || $past(wrRes)))
		else $error("go or result changed during conversion");
endmodule : sas_sequencer

// ==== sim/sas_analog_model.sv ====
module sas_analog_model (
	input wire logic clk_sys,
	input wire logic [7:0] dacCode,
	input wire logic analogOn,
	input wire logic [7:0] vin,
	input wire logic rcRun,
	output logic compIn,
	output logic rcClkIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic junk = 1'b0;
	// ==========================================================
	// Comparator
	// Unpowered comparator gives garbage, never a held level
	always @(posedge clk_sys) junk <= ~junk;
	assign compIn = analogOn ? (vin >= dacCode) : junk;
	// ==========================================================
	// RC oscillator
	// Stands still when not asked for; phase unrelated to clk_sys
	initial rcClkIn = 1'b0;
	always #83 rcClkIn = rcRun ? ~rcClkIn : 1'b0;
endmodule : sas_analog_model

// ==== sim/tb.sv ====
`include "sas_map.svh"
`define CHK(nm, ex, ac) begin cmpCount++; if ((ac) !== (ex)) begin \
	failures++; $display("mismatch %s expected %0h seen %0h", nm, ex, ac); \
	end end

module tb
	import sas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0, regRd = 1'b0, sleepReq = 1'b0;
	logic triggerEvent = 1'b0, rcRun = 1'b0;
	logic [7:0] vin = 8'h00;
	logic [7:0] regRdata, dacCode, d;
	logic [3:0] channelSelect;
	logic compIn, rcClkIn, muxValid, analogOn, sampleConnect;
	logic convIrqFlag, wakeReq, timerReset;
	sas_ref_t refSelect;
	int failures = 0, cmpCount = 0, wakeCnt = 0, tmrCnt = 0, n, k;
	logic [7:0] vals [8] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h01, 8'hFE,
		8'h80, 8'h7F};

	sas_sequencer i_dut (.clk_sys, .rst, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .compIn, .rcClkIn, .sleepReq, .triggerEvent,
		.dacCode, .channelSelect, .muxValid, .refSelect, .analogOn,
		.sampleConnect, .convIrqFlag, .wakeReq, .timerReset);
	sas_analog_model i_ana (.clk_sys, .dacCode, .analogOn, .vin, .rcRun,
		.compIn, .rcClkIn);

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (wakeReq === 1'b1) wakeCnt++;
		if (timerReset === 1'b1) tmrCnt++;
	end

	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask : rd

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test

	// Polls go; cycle count is coarse by the two-cycle read
	task automatic waitIdle(output int cyc);
		logic [7:0] v;
		cyc = 0;
		do begin
			rd(`SAS_OFS_CTRL0, v);
			cyc += 2;
		end while (v[`SAS_C0_GO] && cyc < 4000);
		if (cyc >= 4000) begin
			failures++;
			stop_test();
		end
	endtask : waitIdle

	task automatic conv(input logic [2:0] cs, input logic [7:0] v);
		vin <= v;
		rcRun <= (cs[1:0] == 2'b11);
		wr(`SAS_OFS_CTRL1, {1'b0, cs, 4'h0});
		// enable apart from go, then acquisition wait
		wr(`SAS_OFS_CTRL0, 8'h01);
		repeat (20) @(posedge clk_sys);
		wr(`SAS_OFS_CTRL0, 8'h03);
	endtask : conv

	task automatic allZero();
		for (int a = 0; a < 4; a++) begin
			rd(a[1:0], d);
			`CHK("regreset", 8'h00, d)
		end
	endtask : allZero

	function automatic int divOf(input logic [2:0] c);
		return (c[2] ? 4 : 2) << (2 * c[1:0]);
	endfunction : divOf

	// ==========================================================
	// Tests
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		allZero();
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			wr(`SAS_OFS_CTRL0, {2'h0, c[3:0], 2'h0});
			@(posedge clk_sys);
			#1 `CHK("chan", c[3:0], channelSelect)
			`CHK("valid", c < 5 || (c > 7 && c < 14) || c == 15, muxValid)
		end
		for (int r = 0; r < 4; r++) begin
			wr(`SAS_OFS_CTRL1, r[7:0]);
			#1 `CHK("ref", r < 2 ? SAS_REF_VDD : r == 2 ? SAS_REF_EXT :
				SAS_REF_FIXED, refSelect)
		end
		wr(`SAS_OFS_CTRL1, 8'hFF);
		rd(`SAS_OFS_CTRL1, d);
		`CHK("ctrl1", 8'h73, d)
		$display("test select done");
		for (int i = 0; i < 8; i++) begin
			conv(i[2:0], vals[i]);
			waitIdle(n);
			`CHK("track", 1'b1, sampleConnect)
			`CHK("irqpin", 1'b1, convIrqFlag)
			k = 10 * divOf(i[2:0]);
			if (i % 4 != 3) `CHK("tad", 1'b1, n >= k && n <= k + 5)
			rd(`SAS_OFS_RESULT, d);
			`CHK("result", vals[i], d)
			rd(`SAS_OFS_IRQ, d);
			`CHK("flag", 8'h01, d)
			wr(`SAS_OFS_IRQ, 8'h00);
			rd(`SAS_OFS_IRQ, d);
			`CHK("clear", 8'h00, d)
		end
		$display("test convert done");
		wr(`SAS_OFS_IRQ, 8'h02);
		conv(3'b011, 8'hC3);
		sleepReq <= 1'b1;
		k = wakeCnt;
		waitIdle(n);
		`CHK("wake", k + 1, wakeCnt)
		rd(`SAS_OFS_RESULT, d);
		`CHK("sleepres", 8'hC3, d)
		sleepReq <= 1'b0;
		wr(`SAS_OFS_IRQ, 8'h00);
		conv(3'b011, 8'h3C);
		sleepReq <= 1'b1;
		waitIdle(n);
		@(posedge clk_sys);
		#1 `CHK("pwrdown", 1'b0, analogOn)
		rd(`SAS_OFS_CTRL0, d);
		`CHK("enkept", 8'h01, d)
		`CHK("nowake", k + 1, wakeCnt)
		sleepReq <= 1'b0;
		wr(`SAS_OFS_IRQ, 8'h00);
		conv(3'b110, 8'h11);
		repeat (50) @(posedge clk_sys);
		sleepReq <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 `CHK("sleepoff", 1'b0, analogOn)
		rd(`SAS_OFS_CTRL0, d);
		`CHK("sleepgo", 8'h01, d)
		rd(`SAS_OFS_RESULT, d);
		`CHK("sleepkeep", 8'h3C, d)
		rd(`SAS_OFS_IRQ, d);
		`CHK("sleepflag", 8'h00, d)
		sleepReq <= 1'b0;
		$display("test sleep done");
		conv(3'b110, 8'h80);
		repeat (150) @(posedge clk_sys);
		wr(`SAS_OFS_CTRL0, 8'h01);
		rd(`SAS_OFS_RESULT, d);
		`CHK("partial", 8'hFF, d)
		rd(`SAS_OFS_CTRL0, d);
		`CHK("abortgo", 8'h01, d)
		wr(`SAS_OFS_IRQ, 8'h00);
		wr(`SAS_OFS_CTRL1, 8'h00);
		wr(`SAS_OFS_CTRL0, 8'h02);
		repeat (40) @(posedge clk_sys);
		rd(`SAS_OFS_IRQ, d);
		`CHK("offflag", 8'h00, d)
		rd(`SAS_OFS_RESULT, d);
		`CHK("offres", 8'hFF, d)
		$display("test abort done");
		vin <= 8'h96;
		wr(`SAS_OFS_CTRL0, 8'h01);
		repeat (20) @(posedge clk_sys);
		k = tmrCnt;
		triggerEvent <= 1'b1;
		@(posedge clk_sys);
		triggerEvent <= 1'b0;
		#1 `CHK("hold", 1'b0, sampleConnect)
		repeat (2) @(posedge clk_sys);
		#1 `CHK("trial", 8'h80, dacCode)
		waitIdle(n);
		`CHK("tmr", k + 1, tmrCnt)
		rd(`SAS_OFS_RESULT, d);
		`CHK("trigres", 8'h96, d)
		$display("test trigger done");
		conv(3'b110, 8'h55);
		repeat (50) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		#1 `CHK("rstoff", 1'b0, analogOn)
		allZero();
		$display("test midreset done");
		stop_test();
	end
endmodule : tb
